// [ssrx_sequencer.v]
// Receive sequencer, circular buffer and AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "ssrx_defines.vh"

module ssrx_sequencer #(
  parameter DEPTH = 256
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Demodulator link, asynchronous to hclk
  input  wire        lnk_clk,
  input  wire [2:0]  lnk_event,
  input  wire [7:0]  lnk_data,
  // Status
  output reg  [2:0]  mode_q,
  output reg         gain_fixed_q
);

  // Sequencer states
  localparam ST_IDLE     = 2'h0;
  localparam ST_SEARCH   = 2'h1;
  localparam ST_PREAMBLE = 2'h2;
  localparam ST_PAYLOAD  = 2'h3;

  // Link synchronisers
  wire       lclk_s;
  wire [10:0] lbus_s;
  reg        lclk_prev_q;
  wire       sym;
  wire [2:0] ev;
  wire [7:0] ev_data;

  ssrx_sync #(.W(1)) u_sync_clk (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (lnk_clk),
    .dout_q  (lclk_s)
  );

  ssrx_sync #(.W(11)) u_sync_bus (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({lnk_event, lnk_data}),
    .dout_q  (lbus_s)
  );

  // One symbol per link clock rising edge; event lines settle long before
  assign sym     = lclk_s & ~lclk_prev_q;
  assign ev      = lbus_s[10:8];
  assign ev_data = lbus_s[7:0];

  // Registers
  reg [1:0]  state_q;
  reg [3:0]  flags_q;
  reg [7:0]  acc_ptr_q;
  reg [7:0]  tx_base_q;
  reg [7:0]  rx_base_q;
  reg [9:0]  window_q;
  reg [15:0] preamble_q;
  reg [7:0]  tx_len_q;
  reg [7:0]  rx_count_q;
  reg [7:0]  last_start_q;
  reg [7:0]  wr_pos_q;
  reg [9:0]  sym_cnt_q;
  reg [15:0] pre_cnt_q;
  reg [7:0]  mem_q [0:DEPTH-1];

  // Bus data phase bookkeeping
  reg        dp_q;
  reg        dp_write_q;
  reg [7:0]  dp_addr_q;

  wire accept = hsel & hready & htrans[1] & (hsize == 3'h2);
  wire wr_cyc = dp_q & dp_write_q;
  wire rd_cyc = dp_q & ~dp_write_q;
  wire sleeping = (mode_q == `SSRX_MODE_SLEEP);
  wire single = (mode_q == `SSRX_MODE_SINGLE);
  wire cont = (mode_q == `SSRX_MODE_CONT);
  wire port_hit = (dp_addr_q == `SSRX_OFF_DATA_PORT) & ~sleeping;
  wire host_mem_wr = wr_cyc & port_hit;
  wire host_mode_wr = wr_cyc & (dp_addr_q == `SSRX_OFF_MODE);
  wire [2:0] new_mode = hwdata[2:0];

  // Link events that matter only while a receive mode is live
  wire rx_live = (state_q != ST_IDLE);
  wire ev_pre = rx_live & sym & (ev == `SSRX_EV_PREAMBLE);
  wire ev_hdr = sym & (state_q == ST_PREAMBLE) & (ev == `SSRX_EV_HEADER);
  wire in_pay = sym & (state_q == ST_PAYLOAD);
  wire ev_byte = in_pay & (ev == `SSRX_EV_BYTE);
  wire ev_end = in_pay & ((ev == `SSRX_EV_END_OK) |
                          (ev == `SSRX_EV_END_BAD));
  wire ev_lost = in_pay & (ev == `SSRX_EV_LOST);
  wire searching = (state_q == ST_SEARCH) | (state_q == ST_PREAMBLE);
  // Window expiry only counts while not receiving
  wire expire = single & searching & sym & (window_q != 10'h000) &
                (sym_cnt_q + 10'h001 >= window_q);
  wire pre_long = ev_pre & (state_q == ST_PREAMBLE) &
                  (pre_cnt_q >= preamble_q);

  // Flag sources
  reg [3:0] flag_set;
  reg [3:0] flag_clr;
  always @* begin
    flag_set = 4'h0;
    flag_set[`SSRX_FLG_HEADER]  = ev_hdr;
    flag_set[`SSRX_FLG_DONE]    = ev_end;
    flag_set[`SSRX_FLG_CRC]     = ev_end & (ev == `SSRX_EV_END_BAD);
    flag_set[`SSRX_FLG_TIMEOUT] = expire | (single & ev_lost);
    flag_clr = (wr_cyc && dp_addr_q == `SSRX_OFF_FLAGS) ?
               hwdata[3:0] : 4'h0;
  end

  // Bus slave: one wait state, so a write lands before the next access
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q       <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (dp_q) begin
        dp_q      <= 1'b0;
        hreadyout <= 1'b1;
      end else if (accept) begin
        dp_q       <= 1'b1;
        dp_write_q <= hwrite;
        dp_addr_q  <= {haddr[7:2], 2'b00};
        hreadyout  <= 1'b0;
      end
    end
  end

  // Read data mux; unmapped offsets read as zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_cyc) begin
      case (dp_addr_q)
        `SSRX_OFF_MODE:       hrdata <= {29'h0, mode_q};
        `SSRX_OFF_FLAGS:      hrdata <= {28'h0, flags_q};
        `SSRX_OFF_ACCESS_PTR: hrdata <= {24'h0, acc_ptr_q};
        `SSRX_OFF_DATA_PORT:
          hrdata <= sleeping ? 32'h0 : {24'h0, mem_q[acc_ptr_q]};
        `SSRX_OFF_TX_BASE:    hrdata <= {24'h0, tx_base_q};
        `SSRX_OFF_RX_BASE:    hrdata <= {24'h0, rx_base_q};
        `SSRX_OFF_WINDOW:     hrdata <= {22'h0, window_q};
        `SSRX_OFF_PREAMBLE:   hrdata <= {16'h0, preamble_q};
        `SSRX_OFF_TX_LEN:     hrdata <= {24'h0, tx_len_q};
        `SSRX_OFF_RX_COUNT:   hrdata <= {24'h0, rx_count_q};
        `SSRX_OFF_LAST_START: hrdata <= {24'h0, last_start_q};
        `SSRX_OFF_WRITE_POS:  hrdata <= {24'h0, wr_pos_q};
        `SSRX_OFF_STATUS:
          hrdata <= {28'h0, state_q == ST_PAYLOAD, gain_fixed_q, state_q};
        default:              hrdata <= 32'h00000000;
      endcase
    end
  end

  // Configuration registers and the host access pointer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ptr_q  <= 8'h00;
      tx_base_q  <= `SSRX_RST_TX_BASE;
      rx_base_q  <= `SSRX_RST_RX_BASE;
      window_q   <= `SSRX_RST_WINDOW;
      preamble_q <= `SSRX_RST_PREAMBLE;
      tx_len_q   <= `SSRX_RST_TX_LEN;
    end else if (dp_q) begin
      // Pointer arithmetic wraps at 256 by width
      if (port_hit) begin
        acc_ptr_q <= acc_ptr_q + 8'h01;
      end else if (wr_cyc) begin
        case (dp_addr_q)
          `SSRX_OFF_ACCESS_PTR: acc_ptr_q  <= hwdata[7:0];
          `SSRX_OFF_TX_BASE:    tx_base_q  <= hwdata[7:0];
          `SSRX_OFF_RX_BASE:    rx_base_q  <= hwdata[7:0];
          `SSRX_OFF_WINDOW:     window_q   <= hwdata[9:0];
          `SSRX_OFF_PREAMBLE:   preamble_q <= hwdata[15:0];
          `SSRX_OFF_TX_LEN:     tx_len_q   <= hwdata[7:0];
          default:              tx_len_q   <= tx_len_q;
        endcase
      end
    end
  end

  // Sticky flags: a set in the clearing cycle survives
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // Buffer: cleared in sleep; the modem wins a same-address collision
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (sleeping) begin
          mem_q[i] <= 8'h00;
        end else if (ev_byte && wr_pos_q == i[7:0]) begin
          mem_q[i] <= ev_data;
        end else if (host_mem_wr && acc_ptr_q == i[7:0]) begin
          mem_q[i] <= hwdata[7:0];
        end
      end
    end
  end

  // Mode, sequencer state, counters and write position
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q       <= `SSRX_RST_MODE;
      state_q      <= ST_IDLE;
      lclk_prev_q  <= 1'b0;
      gain_fixed_q <= 1'b0;
      sym_cnt_q    <= 10'h000;
      pre_cnt_q    <= 16'h0000;
      rx_count_q   <= 8'h00;
      last_start_q <= 8'h00;
      wr_pos_q     <= 8'h00;
    end else begin
      lclk_prev_q <= lclk_s;
      if (host_mode_wr) begin
        mode_q       <= new_mode;
        gain_fixed_q <= 1'b0;
        pre_cnt_q    <= 16'h0000;
        if (new_mode == `SSRX_MODE_SINGLE) begin
          // Timer is absolute: it starts from entry
          sym_cnt_q <= 10'h000;
          state_q   <= ST_SEARCH;
          wr_pos_q  <= rx_base_q;
        end else if (new_mode == `SSRX_MODE_CONT) begin
          state_q <= (state_q == ST_IDLE || !cont) ? ST_SEARCH : state_q;
          // Write position kept while continuous stays selected
          if (!cont) begin
            wr_pos_q <= rx_base_q;
          end
        end else begin
          state_q <= ST_IDLE;
        end
      end else begin
        if (single && sym && sym_cnt_q != 10'h3FF) begin
          sym_cnt_q <= sym_cnt_q + 10'h001;
        end
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_IDLE;
          end
          ST_SEARCH: begin
            if (expire) begin
              mode_q  <= `SSRX_MODE_STANDBY;
              state_q <= ST_IDLE;
            end else if (ev_pre) begin
              pre_cnt_q <= 16'h0001;
              state_q   <= ST_PREAMBLE;
            end
          end
          ST_PREAMBLE: begin
            if (expire) begin
              mode_q  <= `SSRX_MODE_STANDBY;
              state_q <= ST_IDLE;
            end else if (pre_long) begin
              pre_cnt_q <= 16'h0000;
              state_q   <= ST_SEARCH;
            end else if (ev_pre) begin
              pre_cnt_q <= pre_cnt_q + 16'h0001;
            end else if (ev_hdr) begin
              // Gain fixed once the preamble is accepted
              gain_fixed_q <= 1'b1;
              rx_count_q   <= 8'h00;
              last_start_q <= wr_pos_q;
              state_q      <= ST_PAYLOAD;
            end else if (sym) begin
              state_q <= ST_SEARCH;
            end
          end
          ST_PAYLOAD: begin
            if (ev_byte) begin
              wr_pos_q   <= wr_pos_q + 8'h01;
              rx_count_q <= rx_count_q + 8'h01;
            end else if (ev_end || ev_lost) begin
              gain_fixed_q <= 1'b0;
              if (single) begin
                mode_q  <= `SSRX_MODE_STANDBY;
                state_q <= ST_IDLE;
              end else begin
                state_q <= ST_SEARCH;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // ssrx_sequencer

`default_nettype wire

// [ssrx_defines.vh]
// Constants for the spread-spectrum receive sequencer
`ifndef SSRX_DEFINES_VH
`define SSRX_DEFINES_VH

// Register byte offsets on the AHB-Lite bus
`define SSRX_OFF_MODE       8'h00
`define SSRX_OFF_FLAGS      8'h04
`define SSRX_OFF_ACCESS_PTR 8'h08
`define SSRX_OFF_DATA_PORT  8'h0C
`define SSRX_OFF_TX_BASE    8'h10
`define SSRX_OFF_RX_BASE    8'h14
`define SSRX_OFF_WINDOW     8'h18
`define SSRX_OFF_PREAMBLE   8'h1C
`define SSRX_OFF_TX_LEN     8'h20
`define SSRX_OFF_RX_COUNT   8'h24
`define SSRX_OFF_LAST_START 8'h28
`define SSRX_OFF_WRITE_POS  8'h2C
`define SSRX_OFF_STATUS     8'h30

// Operating mode codes
`define SSRX_MODE_SLEEP     3'h0
`define SSRX_MODE_STANDBY   3'h1
`define SSRX_MODE_RXSYNTH   3'h2
`define SSRX_MODE_CONT      3'h3
`define SSRX_MODE_SINGLE    3'h4

// Flag bit positions in the interrupt flag set
`define SSRX_FLG_TIMEOUT    0
`define SSRX_FLG_DONE       1
`define SSRX_FLG_CRC        2
`define SSRX_FLG_HEADER     3

// Link event codes, one per link clock rising edge
`define SSRX_EV_NOISE       3'h0
`define SSRX_EV_PREAMBLE    3'h1
`define SSRX_EV_HEADER      3'h2
`define SSRX_EV_BYTE        3'h3
`define SSRX_EV_END_OK      3'h4
`define SSRX_EV_END_BAD     3'h5
`define SSRX_EV_LOST        3'h6

// Reset values
`define SSRX_RST_MODE       3'h0
`define SSRX_RST_TX_BASE    8'h80
`define SSRX_RST_RX_BASE    8'h00
`define SSRX_RST_WINDOW     10'h064
`define SSRX_RST_PREAMBLE   16'h0008
`define SSRX_RST_TX_LEN     8'h01

`endif

// [ssrx_sync.v]
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module ssrx_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // Asynchronous input and filtered result
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout_q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // Only the second stage reads the first; change taken once 2 and 3 agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q   <= {W{1'b0}};
      s2_q   <= {W{1'b0}};
      s3_q   <= {W{1'b0}};
      dout_q <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end

endmodule // ssrx_sync

`default_nettype wire

// [ssrx_checker.sv]
// Port checker for the receive sequencer
`timescale 1ns/1ns
`default_nettype none
module ssrx_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Status
  input wire logic [2:0]  mode_q,
  input wire logic        gain_fixed_q
);
  logic take;
  logic wr_mode_q;
  logic rd_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase accepted at this edge
  assign take = hsel && hready && htrans[1] && hsize == 3'h2 && hreadyout;
  // Data phase markers; a host mode write may move the mode anywhere
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_mode_q <= 1'b0;
      rd_q      <= 1'b0;
    end else begin
      wr_mode_q <= take && hwrite && haddr[7:2] == 6'h00;
      rd_q      <= take && !hwrite;
    end
  end
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("data phase not two cycles");
  ready_cause_a: assert property (!hreadyout |-> $past(take))
    else $error("wait state without a transfer");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_q))
    else $error("read data moved without a read");
  cont_stays_a: assert property (
    (mode_q == 3'h3 && !wr_mode_q) |=> mode_q == 3'h3)
    else $error("continuous receive left on its own");
  single_exit_a: assert property (
    (mode_q == 3'h4 && !wr_mode_q) |=> mode_q == 3'h4 || mode_q == 3'h1)
    else $error("one-shot left to a mode other than standby");
  quiet_mode_a: assert property (
    (mode_q < 3'h3 && !wr_mode_q) |=> $stable(mode_q))
    else $error("quiet mode changed on its own");
  gain_rise_a: assert property (
    $rose(gain_fixed_q) |-> mode_q == 3'h3 || mode_q == 3'h4)
    else $error("gain fixed outside receive");
endmodule // ssrx_checker
`default_nettype wire

// [ssrx_link_model.sv]
// Demodulator-side model driving the symbol link
`timescale 1ns/1ns
`default_nettype none
module ssrx_link_model (
  // Symbol link toward the sequencer
  output var logic       lnk_clk,
  output var logic [2:0] lnk_event,
  output var logic [7:0] lnk_data
);
  // Link clock stands still low between symbols
  initial begin
    lnk_clk   = 1'b0;
    lnk_event = 3'h0;
    lnk_data  = 8'h5A;
  end
  // One 80 ns symbol; codes change at the falling edge so they are
  // settled 40 ns before the rising edge that carries them
  // Non-blocking, so a change on a sampling edge is seen one edge later
  task automatic send(input logic [2:0] ev, input logic [7:0] d);
    begin
      lnk_event <= ev;
      lnk_data  <= d;
      #40 lnk_clk <= 1'b1;
      #40 lnk_clk <= 1'b0;
    end
  endtask
  // Byte lane no longer valid once the link rests: show the inverse,
  // never a stale copy; kept out of send so back to back symbols do not
  // drive the lane twice in one step
  task automatic rest;
    lnk_data <= ~lnk_data;
  endtask
endmodule // ssrx_link_model
`default_nettype wire

// [ssrx_sequencer_tb.sv]
// Self-checking bench for the receive sequencer
`timescale 1ns/1ns
`default_nettype none
`include "ssrx_defines.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t ns: got %h expected %h", $time, (a), (e)); end end
module ssrx_sequencer_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         lnk_clk;
  wire  [2:0]  lnk_event;
  wire  [7:0]  lnk_data;
  wire  [2:0]  mode_q;
  wire         gain_fixed_q;
  logic [7:0]  pay [3] = '{8'h11, 8'h22, 8'h33};
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  ssrx_sequencer #(.DEPTH(256)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lnk_clk(lnk_clk), .lnk_event(lnk_event),
    .lnk_data(lnk_data), .mode_q(mode_q), .gain_fixed_q(gain_fixed_q));
  ssrx_link_model lm_u (
    .lnk_clk(lnk_clk), .lnk_event(lnk_event), .lnk_data(lnk_data));
  always #5 hclk = ~hclk;
  // Hang guard, far above the fewer than one thousand cycles the tests need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Single AHB-Lite transfer; request held until hready seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    begin
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    begin
      xfer(1'b0, a, 32'h0, r);
      `CHK(r, e)
    end
  endtask
  // Sync plus update latency is five cycles; eight leaves margin
  task automatic settle;
    begin
      lm_u.rest();
      repeat (8) @(posedge hclk);
    end
  endtask
  // Preamble, header, n bytes from the table, then the closing code
  task automatic pkt(input int n, input logic [2:0] fin);
    begin
      lm_u.send(`SSRX_EV_PREAMBLE, 8'h00);
      lm_u.send(`SSRX_EV_HEADER, 8'h00);
      for (int i = 0; i < n; i++) lm_u.send(`SSRX_EV_BYTE, pay[i]);
      lm_u.send(fin, 8'h00);
      settle();
    end
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(`SSRX_OFF_TX_BASE, 32'h80);
    chk(`SSRX_OFF_WINDOW, 32'h64);
    chk(8'h3C, 32'h0);
    done("reset");
    wr(`SSRX_OFF_MODE, 32'h1);
    wr(`SSRX_OFF_TX_BASE, 32'hFE);
    wr(`SSRX_OFF_TX_LEN, 32'h3);
    wr(`SSRX_OFF_ACCESS_PTR, 32'hFE);
    // Inverted bytes, so later receive checks can only pass on modem writes
    for (int i = 0; i < 3; i++) begin
      wr(`SSRX_OFF_DATA_PORT, {24'h0, ~pay[i]});
    end
    chk(`SSRX_OFF_TX_LEN, 32'h3);
    chk(`SSRX_OFF_ACCESS_PTR, 32'h01);
    wr(`SSRX_OFF_ACCESS_PTR, 32'hFE);
    for (int i = 0; i < 3; i++) begin
      chk(`SSRX_OFF_DATA_PORT, {24'h0, ~pay[i]});
    end
    done("buffer fill");
    wr(`SSRX_OFF_RX_BASE, 32'hFE);
    wr(`SSRX_OFF_MODE, 32'h4);
    pkt(3, `SSRX_EV_END_BAD);
    chk(`SSRX_OFF_FLAGS, 32'hE);
    chk(`SSRX_OFF_MODE, 32'h1);
    chk(`SSRX_OFF_RX_COUNT, 32'h3);
    chk(`SSRX_OFF_WRITE_POS, 32'h01);
    chk(`SSRX_OFF_LAST_START, 32'hFE);
    wr(`SSRX_OFF_ACCESS_PTR, 32'hFE);
    for (int i = 0; i < 3; i++) begin
      chk(`SSRX_OFF_DATA_PORT, {24'h0, pay[i]});
    end
    wr(`SSRX_OFF_FLAGS, 32'h2);
    chk(`SSRX_OFF_FLAGS, 32'hC);
    wr(`SSRX_OFF_FLAGS, 32'hF);
    done("one-shot packet");
    wr(`SSRX_OFF_WINDOW, 32'h4);
    wr(`SSRX_OFF_MODE, 32'h4);
    repeat (3) lm_u.send(`SSRX_EV_NOISE, 8'h00);
    settle();
    chk(`SSRX_OFF_FLAGS, 32'h0);
    lm_u.send(`SSRX_EV_NOISE, 8'h00);
    settle();
    chk(`SSRX_OFF_FLAGS, 32'h1);
    chk(`SSRX_OFF_MODE, 32'h1);
    wr(`SSRX_OFF_FLAGS, 32'h1);
    wr(`SSRX_OFF_ACCESS_PTR, 32'hFE);
    wr(`SSRX_OFF_MODE, 32'h4);
    pkt(3, `SSRX_EV_BYTE);
    `CHK(gain_fixed_q, 1'b1)
    chk(`SSRX_OFF_MODE, 32'h4);
    chk(`SSRX_OFF_STATUS, 32'hF);
    lm_u.send(`SSRX_EV_LOST, 8'h00);
    settle();
    `CHK(gain_fixed_q, 1'b0)
    chk(`SSRX_OFF_FLAGS, 32'h9);
    chk(`SSRX_OFF_MODE, 32'h1);
    wr(`SSRX_OFF_FLAGS, 32'hF);
    done("timeout");
    wr(`SSRX_OFF_PREAMBLE, 32'h2);
    wr(`SSRX_OFF_RX_BASE, 32'h10);
    wr(`SSRX_OFF_MODE, 32'h3);
    repeat (3) lm_u.send(`SSRX_EV_PREAMBLE, 8'h00);
    lm_u.send(`SSRX_EV_HEADER, 8'h00);
    settle();
    chk(`SSRX_OFF_FLAGS, 32'h0);
    pkt(1, `SSRX_EV_END_OK);
    chk(`SSRX_OFF_FLAGS, 32'hA);
    wr(`SSRX_OFF_FLAGS, 32'hF);
    pkt(2, `SSRX_EV_END_OK);
    repeat (6) lm_u.send(`SSRX_EV_NOISE, 8'h00);
    settle();
    chk(`SSRX_OFF_FLAGS, 32'hA);
    chk(`SSRX_OFF_MODE, 32'h3);
    chk(`SSRX_OFF_LAST_START, 32'h11);
    chk(`SSRX_OFF_RX_COUNT, 32'h2);
    wr(`SSRX_OFF_MODE, 32'h3);
    chk(`SSRX_OFF_WRITE_POS, 32'h13);
    wr(`SSRX_OFF_ACCESS_PTR, 32'h10);
    chk(`SSRX_OFF_DATA_PORT, 32'h11);
    chk(`SSRX_OFF_DATA_PORT, 32'h11);
    chk(`SSRX_OFF_DATA_PORT, 32'h22);
    done("continuous");
    print_verdict();
  end
endmodule // ssrx_sequencer_tb
bind ssrx_sequencer ssrx_checker chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .mode_q(mode_q), .gain_fixed_q(gain_fixed_q));
`default_nettype wire
